// ### tb_crosspoint_serial_config.sv
// Bench joining controller and device; software runs over Wishbone.
// Assumes the package constants and the hand-over register map.
`timescale 1ns/1ps
`default_nettype none
module tb_crosspoint_serial_config
   import xpt_pkg::*;
;
   logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, wb_ack, pending;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r;
   logic [NUM_OUT-1:0][IDX_W-1:0] route_sel, exp_sel;
   logic [NUM_OUT-1:0] route_on, exp_on;
   logic [39:0] fa, fb;
   int bad_count = 0;
   int checks = 0;
   int cycles = 0;

   xpt_if link_if ();
   xpt_controller i_xpt_controller (.clk_i(clk_i), .rst_i(rst_i),
      .adr_i(wb_adr), .dat_i(wb_dat_w), .dat_o(wb_dat_r), .we_i(wb_we),
      .sel_i(wb_sel), .cyc_i(wb_cyc), .stb_i(wb_stb), .ack_o(wb_ack),
      .link(link_if.controller));
   xpt_device i_xpt_device (.clk_i(clk_i), .rst_i(rst_i),
      .link(link_if.device), .route_sel_o(route_sel),
      .route_on_o(route_on), .pending_o(pending));
   xpt_props i_xpt_props (.clk_i(clk_i), .rst_i(rst_i),
      .sclk(link_if.sclk), .cs_n(link_if.cs_n), .din(link_if.din),
      .dout(link_if.dout), .mode(link_if.mode), .cfg(link_if.cfg),
      .clear(link_if.clear),
      .fanout_input_zero_pin(link_if.fanout_input_zero_pin));

   // ------------------------------------------------------------
   // Clock, reset, timeout
   // ------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: timeout", $time);
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [39:0] got, input logic [39:0] exp,
      input string what);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask : check

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      wb_adr <= a;
      wb_we <= w;
      wb_dat_w <= d;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic start(input logic m, input logic [6:0] len,
      input logic c, input logic fan, input logic [95:0] tx);
      logic [31:0] q, w;
      w = 32'h0000_0000;
      w[C_GO] = 1'b1;
      w[C_MODE] = m;
      w[C_CFG] = c;
      w[C_FAN] = fan;
      w[C_LEN_LSB +: LEN_W] = len;
      wb(TX0_OFF, 1'b1, tx[31:0], q);
      wb(TX1_OFF, 1'b1, tx[63:32], q);
      wb(TX2_OFF, 1'b1, tx[95:64], q);
      wb(CTRL_OFF, 1'b1, w, q);
   endtask : start

   task automatic finish();
      logic [31:0] q;
      int n;
      n = 0;
      do
      begin
         wb(STAT_OFF, 1'b0, 32'h0000_0000, q);
         n++;
      end
      while (q[S_BUSY] !== 1'b0 && n < 1000);
      check(40'(q[S_BUSY]), 40'h0, "busy cleared");
      repeat (12) @(posedge clk_i);
   endtask : finish

   task automatic send(input logic m, input logic [6:0] len,
      input logic c, input logic [95:0] tx);
      start(m, len, c, 1'b0, tx);
      finish();
   endtask : send

   // Frame with distinct inputs, one output switched off
   function automatic logic [39:0] frame(input int base, input int offn);
      for (int n = 0; n < NUM_OUT; n++)
      begin
         frame[5*n +: 4] = 4'(base + 3*n);
         frame[5*n+4] = (n == offn);
      end
   endfunction : frame

   task automatic expect_frame(input logic [39:0] f);
      for (int n = 0; n < NUM_OUT; n++)
      begin
         exp_sel[n] = f[5*n +: 4];
         exp_on[n] = !f[5*n+4];
      end
   endtask : expect_frame

   task automatic chk_routes(input string what);
      check(40'(route_sel), 40'(exp_sel), what);
      check(40'(route_on), 40'(exp_on), what);
   endtask : chk_routes

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_full();
      fa = frame(1, 3);
      send(1'b0, 7'd40, 1'b1, 96'(fa));
      expect_frame(fa);
      chk_routes("full frame");
      check(40'(pending), 40'h0, "pending after cfg");
   endtask : s_full

   task automatic s_cfg_gate();
      fb = frame(7, 6);
      send(1'b0, 7'd40, 1'b0, 96'(fb));
      chk_routes("loaded without cfg");
      check(40'(pending), 40'h1, "pending set");
      send(1'b0, 7'd0, 1'b1, 96'h0);
      expect_frame(fb);
      chk_routes("late cfg");
      // Addressed mode: a stray transfer would move output 6
      send(1'b1, 7'd0, 1'b1, 96'h0);
      chk_routes("empty cfg");
   endtask : s_cfg_gate

   task automatic s_word();
      for (int k = 0; k < NUM_OUT; k++)
      begin
         send(1'b1, 7'd8, 1'b1, 96'({k == 5, 4'(15 - k), 3'(k)}));
         exp_sel[k] = 4'(15 - k);
         exp_on[k] = (k != 5);
         chk_routes("addressed word");
      end
   endtask : s_word

   task automatic s_chain();
      logic [31:0] q;
      fa = frame(2, 0);
      fb = frame(9, 7);
      send(1'b0, 7'd80, 1'b1, {16'h0000, fb, fa});
      expect_frame(fb);
      chk_routes("double frame");
      wb(RX_OFF, 1'b0, 32'h0000_0000, q);
      check(40'(q), 40'(fa[39:8]), "forwarded bits");
   endtask : s_chain

   task automatic s_pins();
      logic [31:0] q;
      wb(8'h40, 1'b0, 32'h0000_0000, q);
      check(40'(q), 40'h0, "unmapped read");
      start(1'b0, 7'd40, 1'b0, 1'b1, 96'(frame(5, 1)));
      repeat (60) @(posedge clk_i);
      check(40'(route_on), 40'hFF, "broadcast on");
      check(40'(route_sel), 40'h0, "broadcast input");
      finish();
      wb(CTRL_OFF, 1'b1, 32'h0000_0000, q);
      repeat (8) @(posedge clk_i);
      chk_routes("after broadcast");
      wb(CTRL_OFF, 1'b1, 32'h0000_0018, q);
      repeat (8) @(posedge clk_i);
      check(40'(route_on), 40'h0, "clear wins");
      wb(CTRL_OFF, 1'b1, 32'h0000_0000, q);
      repeat (8) @(posedge clk_i);
      exp_sel = '0;
      exp_on = '0;
      chk_routes("after clear");
   endtask : s_pins

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_i = 1'b1;
      wb_adr = 8'h00;
      wb_dat_w = 32'h0000_0000;
      wb_we = 1'b0;
      wb_sel = 4'hF;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      s_full();
      s_cfg_gate();
      s_word();
      s_chain();
      s_pins();
      report_and_stop();
   end
endmodule : tb_crosspoint_serial_config
`default_nettype wire

// ### xpt_controller.sv
// Serial controller: Wishbone registers drive the configuration pins.
// Assumes a classic Wishbone master on the same clock.
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module xpt_controller
   import xpt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   xpt_if.controller link
);
   typedef enum logic [2:0] {IDLE, SETUP, HI, LO, TAIL, TAILH, CFGP}
      ctl_st_t;
   typedef struct packed {
      ctl_st_t st;
      logic ack;
      logic [31:0] dat;
      logic mode;
      logic cfg_en;
      logic clr;
      logic fan;
      logic [LEN_W-1:0] len;
      logic [LEN_W-1:0] bitc;
      logic [TX_BITS-1:0] tx;
      logic [31:0] rx;
      logic [CNT_W-1:0] cnt;
      logic sck;
      logic csn;
      logic din;
      logic cfg;
   } ctl_state_t;
   ctl_state_t r_reg, r_next;
   logic dout_s;
   logic req;
   logic wr;
   logic tick;
   logic [LEN_W-1:0] bit_nx;
   localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(HALF_CYC - 1);

   // Device serial output is a pin
   xpt_sync #(
      .W(1),
      .INIT(1'b0)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(link.dout),
      .q_o(dout_s)
   );

   // Byte-lane merge of a register write
   function automatic logic [31:0] merge(
      input logic [31:0] o,
      input logic [31:0] d,
      input logic [3:0] s
   );
      for (int b = 0; b < 4; b++)
         merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
   endfunction : merge

   assign req = cyc_i & stb_i & ~r_reg.ack;
   // Writes land at the edge where the master samples ack high
   assign wr = cyc_i & stb_i & we_i & r_reg.ack;
   assign tick = (r_reg.cnt == '0);
   assign bit_nx = r_reg.bitc + LEN_W'(1);

   // ---------------------------------------------------------------
   // Register slave and serial sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      r_next = r_reg;
      r_next.ack = req;
      r_next.cnt = tick ? HALF_LD : r_reg.cnt - CNT_W'(1);
      // Read mux, unmapped reads zero
      unique case (adr_i)
         CTRL_OFF: r_next.dat = {17'h00000, r_reg.len, 3'h0, r_reg.fan,
            r_reg.clr, r_reg.cfg_en, r_reg.mode, 1'b0};
         STAT_OFF: r_next.dat = {31'h00000000, r_reg.st != IDLE};
         TX0_OFF: r_next.dat = r_reg.tx[31:0];
         TX1_OFF: r_next.dat = r_reg.tx[63:32];
         TX2_OFF: r_next.dat = r_reg.tx[95:64];
         RX_OFF: r_next.dat = r_reg.rx;
         default: r_next.dat = 32'h00000000;
      endcase
      // Writes: data words only while idle
      if (wr && r_reg.st == IDLE)
      begin
         if (adr_i == TX0_OFF)
            r_next.tx[31:0] = merge(r_reg.tx[31:0], dat_i, sel_i);
         if (adr_i == TX1_OFF)
            r_next.tx[63:32] = merge(r_reg.tx[63:32], dat_i, sel_i);
         if (adr_i == TX2_OFF)
            r_next.tx[95:64] = merge(r_reg.tx[95:64], dat_i, sel_i);
      end
      if (wr && adr_i == CTRL_OFF && sel_i[0])
      begin
         r_next.clr = dat_i[C_CLR];
         r_next.fan = dat_i[C_FAN];
         if (r_reg.st == IDLE)
         begin
            r_next.mode = dat_i[C_MODE];
            r_next.cfg_en = dat_i[C_CFG];
         end
      end
      if (wr && adr_i == CTRL_OFF && sel_i[1] && r_reg.st == IDLE)
         r_next.len = dat_i[C_LEN_LSB +: LEN_W];
      // Serial sequencer
      unique case (r_reg.st)
         IDLE:
            if (wr && adr_i == CTRL_OFF && sel_i[0] && dat_i[C_GO])
            begin
               r_next.cnt = HALF_LD;
               r_next.bitc = '0;
               if (r_next.len == '0)
               begin
                  r_next.cfg = 1'b1;
                  r_next.st = CFGP;
               end
               else
               begin
                  r_next.csn = 1'b0;
                  r_next.st = SETUP;
               end
            end
         SETUP:
            if (tick)
            begin
               r_next.sck = 1'b1;
               r_next.din = r_reg.tx[0];
               r_next.st = HI;
            end
         HI:
            if (tick)
            begin
               r_next.sck = 1'b0;
               r_next.st = LO;
            end
         LO:
            if (tick)
            begin
               r_next.rx = {dout_s, r_reg.rx[31:1]};
               r_next.tx = r_reg.tx >> 1;
               r_next.bitc = bit_nx;
               if (bit_nx == r_reg.len)
               begin
                  r_next.csn = 1'b1;
                  r_next.st = TAIL;
               end
               else
               begin
                  r_next.sck = 1'b1;
                  r_next.din = r_reg.tx[1];
                  r_next.st = HI;
               end
            end
         TAIL:
            if (tick)
            begin
               r_next.sck = 1'b1;
               r_next.st = TAILH;
            end
         TAILH:
            if (tick)
            begin
               r_next.sck = 1'b0;
               r_next.cfg = r_reg.cfg_en;
               r_next.st = r_reg.cfg_en ? CFGP : IDLE;
            end
         CFGP:
            if (tick)
            begin
               r_next.cfg = 1'b0;
               r_next.st = IDLE;
            end
      endcase
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_reg <= '0;
         r_reg.st <= IDLE;
         r_reg.csn <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign ack_o = r_reg.ack;
   assign dat_o = r_reg.dat;
   assign link.sclk = r_reg.sck;
   assign link.cs_n = r_reg.csn;
   assign link.din = r_reg.din;
   assign link.mode = r_reg.mode;
   assign link.cfg = r_reg.cfg;
   assign link.clear = r_reg.clr;
   assign link.fanout_input_zero_pin = r_reg.fan;
endmodule : xpt_controller
`default_nettype wire

// ### xpt_device.sv
// Crosspoint configuration logic: load stage, output registers, pins.
// Assumes serial pins arrive asynchronously and are oversampled.
`timescale 1ns/1ps
`default_nettype none
module xpt_device
   import xpt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   xpt_if.device link,
   output logic [NUM_OUT-1:0][IDX_W-1:0] route_sel_o,
   output logic [NUM_OUT-1:0] route_on_o,
   output logic pending_o
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int NPIN = 7;
   localparam logic [NPIN-1:0] PIN_INIT = 7'h02;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   logic sck_s;
   logic csn_s;
   logic din_s;
   logic mode_s;
   logic cfg_s;
   logic clr_s;
   logic fan_s;

   // Bundle pins, select idles high
   assign pin_raw = {link.fanout_input_zero_pin, link.clear, link.cfg,
      link.mode, link.din, link.cs_n, link.sclk};

   xpt_sync #(
      .W(NPIN),
      .INIT(PIN_INIT)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );

   // Unpack synchronised pins
   assign sck_s = pin_s[0];
   assign csn_s = pin_s[1];
   assign din_s = pin_s[2];
   assign mode_s = pin_s[3];
   assign cfg_s = pin_s[4];
   assign clr_s = pin_s[5];
   assign fan_s = pin_s[6];

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FRAME_BITS-1:0] shift;
      logic armed;
      logic sck_d;
      logic cfg_d;
      logic loaded;
      logic [NUM_OUT-1:0][IDX_W-1:0] sel;
      logic [NUM_OUT-1:0] off;
      logic [NUM_OUT-1:0][IDX_W-1:0] sel_q;
      logic [NUM_OUT-1:0] on_q;
      logic dout;
   } dev_state_t;

   dev_state_t r_reg, r_next;

   // ---------------------------------------------------------------
   // Field decoders
   // ---------------------------------------------------------------

   // Input index of output n within a full frame
   function automatic logic [IDX_W-1:0] frame_sel(
      input logic [FRAME_BITS-1:0] f,
      input int n
   );
      frame_sel = f[n*FIELD_W +: IDX_W];
   endfunction : frame_sel

   // Off flag of output n within a full frame
   function automatic logic frame_off(
      input logic [FRAME_BITS-1:0] f,
      input int n
   );
      frame_off = f[n*FIELD_W + OFF_POS];
   endfunction : frame_off

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   logic sck_rise;
   logic sck_fall;
   logic cfg_rise;
   logic shift_en;
   logic [WORD_BITS-1:0] word;
   logic [W_OSEL_W-1:0] w_out;

   // Edge detection on synchronised pins
   assign sck_rise = sck_s & ~r_reg.sck_d;
   assign sck_fall = ~sck_s & r_reg.sck_d;
   assign cfg_rise = cfg_s & ~r_reg.cfg_d;
   assign shift_en = sck_fall & r_reg.armed & ~csn_s;

   // Addressed word sits in the top eight bits once shifted
   assign word = r_reg.shift[WORD_LSB +: WORD_BITS];
   assign w_out = word[W_OSEL_LSB +: W_OSEL_W];

   // Load stage, output registers and pin views
   always_comb
   begin
      r_next = r_reg;
      r_next.sck_d = sck_s;
      r_next.cfg_d = cfg_s;

      // Arm on first rising clock after select falls
      if (csn_s)
         r_next.armed = 1'b0;
      else if (sck_rise)
         r_next.armed = 1'b1;

      // Configure transfer, only with fresh data
      if (cfg_rise && r_reg.loaded)
      begin
         r_next.loaded = 1'b0;
         if (!mode_s)
         begin
            for (int n = 0; n < NUM_OUT; n++)
            begin
               r_next.sel[n] = frame_sel(r_reg.shift, n);
               r_next.off[n] = frame_off(r_reg.shift, n);
            end
         end
         else
         begin
            r_next.sel[w_out] = word[W_ISEL_LSB +: IDX_W];
            r_next.off[w_out] = word[W_OFF_BIT];
         end
      end

      // Shift, bit 0 first toward the low end
      if (shift_en)
      begin
         r_next.shift = {din_s, r_reg.shift[FRAME_BITS-1:1]};
         r_next.loaded = 1'b1;
      end

      // Clear overrides any transfer, independent of select
      if (clr_s)
      begin
         for (int n = 0; n < NUM_OUT; n++)
         begin
            r_next.sel[n] = SEL_RST;
            r_next.off[n] = 1'b1;
         end
      end

      // Matrix view: clear, then broadcast, then stored routes
      for (int n = 0; n < NUM_OUT; n++)
      begin
         if (clr_s)
         begin
            r_next.sel_q[n] = SEL_RST;
            r_next.on_q[n] = 1'b0;
         end
         else if (fan_s)
         begin
            r_next.sel_q[n] = SEL_RST;
            r_next.on_q[n] = 1'b1;
         end
         else
         begin
            r_next.sel_q[n] = r_next.sel[n];
            r_next.on_q[n] = ~r_next.off[n];
         end
      end

      // Serial out forwards the low end of the updated register, full-frame only
      r_next.dout = mode_s ? 1'b0 : r_next.shift[0];
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         r_reg <= '0;
         r_reg.off <= '1;
      end
      else
         r_reg <= r_next;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign link.dout = r_reg.dout;
   assign route_sel_o = r_reg.sel_q;
   assign route_on_o = r_reg.on_q;
   assign pending_o = r_reg.loaded;

endmodule : xpt_device
`default_nettype wire

// ### xpt_if.sv
// Pin bundle between the serial controller and the crosspoint device.
// Assumes the bench joins the two ends through one instance.
`timescale 1ns/1ps
`default_nettype none
interface xpt_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic mode;
   logic cfg;
   logic clear;
   logic fanout_input_zero_pin;

   modport device (input sclk, cs_n, din, mode, cfg, clear,
      fanout_input_zero_pin, output dout);
   modport controller (output sclk, cs_n, din, mode, cfg, clear,
      fanout_input_zero_pin, input dout);
endinterface : xpt_if
`default_nettype wire

// ### xpt_pkg.sv
// Shared constants for the crosspoint serial configuration link.
// Assumes a single 10 MHz system clock in both ends.
package xpt_pkg;

   // ---------------------------------------------------------------
   // Switch geometry
   // ---------------------------------------------------------------
   localparam int NUM_OUT = 8;
   localparam int IDX_W = 4;
   localparam int FIELD_W = 5;
   localparam int OFF_POS = 4;
   localparam int FRAME_BITS = 40;
   localparam int WORD_BITS = 8;
   localparam int WORD_LSB = FRAME_BITS - WORD_BITS;
   localparam int W_OSEL_LSB = 0;
   localparam int W_OSEL_W = 3;
   localparam int W_ISEL_LSB = 3;
   localparam int W_OFF_BIT = 7;
   localparam logic [IDX_W-1:0] SEL_RST = 4'h0;

   // ---------------------------------------------------------------
   // Serial clock timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int HALF_NS = 400;
   localparam int HALF_CYC = (HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // ---------------------------------------------------------------
   // Controller register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STAT_OFF = 8'h04;
   localparam logic [7:0] TX0_OFF = 8'h08;
   localparam logic [7:0] TX1_OFF = 8'h0C;
   localparam logic [7:0] TX2_OFF = 8'h10;
   localparam logic [7:0] RX_OFF = 8'h14;
   localparam int C_GO = 0;
   localparam int C_MODE = 1;
   localparam int C_CFG = 2;
   localparam int C_CLR = 3;
   localparam int C_FAN = 4;
   localparam int C_LEN_LSB = 8;
   localparam int LEN_W = 7;
   localparam int TX_BITS = 96;
   localparam int S_BUSY = 0;

endpackage : xpt_pkg

// ### xpt_props.sv
// Checker for the serial configuration pins between the two ends.
// Assumes one clock domain and the pin levels seen by both ends.
`timescale 1ns/1ps
`default_nettype none
module xpt_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic mode,
   input wire logic cfg,
   input wire logic clear,
   input wire logic fanout_input_zero_pin
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // ------------------------------------------------------------
   // Helper: cycles spent in addressed mode
   // ------------------------------------------------------------
   logic [3:0] mode_cnt_reg;
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !mode)
         mode_cnt_reg <= 4'h0;
      else if (mode_cnt_reg != 4'hF)
         mode_cnt_reg <= mode_cnt_reg + 4'h1;
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_cs_setup;
      $fell(cs_n) |-> !sclk ##[1:8] $rose(sclk);
   endproperty
   property p_half_high;
      $rose(sclk) |-> sclk[*4] ##1 !sclk;
   endproperty
   property p_din_hold;
      $fell(sclk) && !cs_n |-> $stable(din);
   endproperty
   property p_tail_rise;
      $rose(cs_n) |-> ##[1:8] $rose(sclk);
   endproperty
   property p_cs_hold;
      $rose(cs_n) |-> cs_n[*8];
   endproperty
   property p_cfg_pulse;
      $rose(cfg) |-> cfg[*4] ##1 !cfg;
   endproperty
   property p_cfg_idle;
      cfg |-> cs_n;
   endproperty
   property p_dout_word;
      mode_cnt_reg >= 4'h8 |-> !dout;
   endproperty

   a_cs_setup: assert property (p_cs_setup)
      else $error("clock did not start low after select");
   a_half_high: assert property (p_half_high)
      else $error("serial clock high phase wrong");
   a_din_hold: assert property (p_din_hold)
      else $error("data changed at sampling edge");
   a_tail_rise: assert property (p_tail_rise)
      else $error("no clock rise after deselect");
   a_cs_hold: assert property (p_cs_hold)
      else $error("select reasserted too soon");
   a_cfg_pulse: assert property (p_cfg_pulse)
      else $error("configure pulse length wrong");
   a_cfg_idle: assert property (p_cfg_idle)
      else $error("configure while selected");
   a_dout_word: assert property (p_dout_word)
      else $error("serial out active in addressed mode");

   // Main scenarios
   c_word_cfg: cover property ($rose(cfg) && mode);
   c_frame: cover property ($fell(cs_n) && !mode);
   c_both_pins: cover property (clear && fanout_input_zero_pin);
endmodule : xpt_props
`default_nettype wire

// ### xpt_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes every bit is a slow level or edge from another domain.
`timescale 1ns/1ps
`default_nettype none
module xpt_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t r_reg, r_next;

   // Second stage reads only the first
   always_comb
   begin
      r_next.s1 = d_i;
      r_next.s2 = r_reg.s1;
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         r_reg <= '{s1: INIT, s2: INIT};
      else
         r_reg <= r_next;
   end

   assign q_o = r_reg.s2;
endmodule : xpt_sync
`default_nettype wire
